// ### bench/comparator_select_status_tb.sv
`timescale 1ns/100ps
module comparator_select_status_tb;
    import ccs_pkg::*;

    logic        clk   = 1'b0;
    logic        nrst  = 1'b0;
    logic [4:0]  addr  = 5'h00;
    logic        rd_s  = 1'b0;
    logic        wr_s  = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0]  be    = 4'h3;
    logic [31:0] rdata;
    logic        wreq;
    logic [2:0]  comp  = 3'h0;
    logic        idle  = 1'b0;
    logic [2:0]  ref_sel;
    logic [5:0]  inv_sel;
    logic [2:0]  run;
    logic        irq;
    logic [15:0] v;
    int          mismatches = 0;
    int          num_checks = 0;

    // 10 MHz system clock
    always #50 clk = ~clk;

    ccs_regs dut (
        .sys_clk_in          (clk),
        .nrst_in             (nrst),
        .avs_address_in      (addr),
        .avs_read_in         (rd_s),
        .avs_write_in        (wr_s),
        .avs_writedata_in    (wdata),
        .avs_byteenable_in   (be),
        .avs_readdata_out    (rdata),
        .avs_waitrequest_out (wreq),
        .comp_out_in         (comp),
        .idle_mode_in        (idle),
        .noninv_ref_sel_out  (ref_sel),
        .inv_sel_out         (inv_sel),
        .comp_run_out        (run),
        .irq_out             (irq)
    );

    // Compare and count
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One bus access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        addr  <= a;
        wdata <= {16'h0000, d};
        rd_s  <= ~w;
        wr_s  <= w;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        if (n >= 50) begin
            mismatches++;
            results;
        end
        q = rdata;
        rd_s <= 1'b0;
        wr_s <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        bus(1'b0, a, 16'h0000, q);
        chk(what, q, exp);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        results;
    end

    // Test sequence
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        chk("irq_rst", irq, 0);
        rd({1'b0, CCS_OFF_STATUS}, 32'h0, "status_rst");
        rd({1'b0, CCS_OFF_CTRL1}, 32'h0, "ctrl_rst");
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            for (int c = 0; c < 4; c++) begin
                v = 16'h000c | 16'(c) | (16'(c & 1) << 4);
                wr(5'(i * 4), v);
                repeat (2) @(posedge clk);
                chk("ref_sel", ref_sel[i], 32'(c & 1));
                chk("inv_sel", inv_sel[2*i+:2], 32'(c));
                rd(5'(i * 4), {16'h0000, v & 16'hfff3}, "ctrl_rb");
            end
            wr(5'(i * 4), 16'h0000);
        end
        $display("test routing done");
        wr({1'b0, CCS_OFF_STATUS}, 16'hffff);
        rd({1'b0, CCS_OFF_STATUS}, 32'h8000, "status_wr");
        wr({1'b0, CCS_OFF_STATUS}, 16'h0000);
        $display("test status write done");
        for (int i = 0; i < 3; i++) begin
            wr(5'(i * 4), 16'h8000);
            comp[i] <= 1'b1;
            repeat (6) @(posedge clk);
            rd({1'b0, CCS_OFF_STATUS}, 32'h0101 << i, "mirror");
            rd(5'(i * 4), 32'h8300, "ctrl_evt");
            comp[i] <= 1'b0;
            repeat (6) @(posedge clk);
            wr(5'(i * 4), 16'h0000);
            rd({1'b0, CCS_OFF_STATUS}, 32'h0, "mirror_clr");
        end
        $display("test mirrors done");
        rd({1'b1, CCS_OFF_IRQ_ST}, 32'h7, "irq_st");
        chk("irq_masked", irq, 0);
        wr({1'b1, CCS_OFF_IRQ_MK}, 16'h0007);
        repeat (2) @(posedge clk);
        chk("irq_on", irq, 1);
        wr({1'b1, CCS_OFF_IRQ_ST}, 16'h0007);
        repeat (2) @(posedge clk);
        chk("irq_clr", irq, 0);
        rd({1'b1, CCS_OFF_IRQ_ST}, 32'h0, "irq_st_clr");
        wr({1'b1, CCS_OFF_IRQ_MK}, 16'h0000);
        repeat (2) @(posedge clk);
        chk("irq_mask_off", irq, 0);
        wr(5'h18, 16'hffff);
        rd(5'h18, 32'h0, "unmapped");
        $display("test irq done");
        wr({1'b0, CCS_OFF_CTRL1}, 16'h8000);
        idle <= 1'b1;
        repeat (5) @(posedge clk);
        chk("run_idle", run, 32'h1);
        wr({1'b0, CCS_OFF_STATUS}, 16'h8000);
        repeat (5) @(posedge clk);
        chk("run_stop", run, 32'h0);
        idle <= 1'b0;
        repeat (5) @(posedge clk);
        chk("run_wake", run, 32'h1);
        $display("test idle done");
        results;
    end
endmodule

// ### src/ccs_pkg.sv
package ccs_pkg;

    // Register byte addresses (three control words, then shared status; interrupt status and mask in the upper bank)
    localparam logic [3:0] CCS_OFF_CTRL1  = 4'h0;
    localparam logic [3:0] CCS_OFF_CTRL2  = 4'h4;
    localparam logic [3:0] CCS_OFF_CTRL3  = 4'h8;
    localparam logic [3:0] CCS_OFF_STATUS = 4'hc;
    localparam logic [3:0] CCS_OFF_IRQ_ST = 4'h0;
    localparam logic [3:0] CCS_OFF_IRQ_MK = 4'h4;

    // Control register field positions
    localparam int CCS_CTRL_REF_SEL_BIT = 4;
    localparam int CCS_CTRL_CH_LSB      = 0;
    localparam int CCS_CTRL_OUT_BIT     = 8;
    localparam int CCS_CTRL_EVT_BIT     = 9;

    // Status register field positions
    localparam int CCS_STAT_IDLE_BIT    = 15;
    localparam int CCS_STAT_EVT_LSB     = 8;
    localparam int CCS_STAT_OUT_LSB     = 0;

    // Reset values
    localparam logic [15:0] CCS_CTRL_RESET = 16'h0000;
    localparam logic [2:0]  CCS_IRQ_RESET  = 3'h0;

    // Number of comparators
    localparam int CCS_NUM = 3;

    // Inverting input selections
    typedef enum logic [1:0] {
        CCS_INV_PIN_B = 2'h0,
        CCS_INV_PIN_C = 2'h1,
        CCS_INV_PIN_D = 2'h2,
        CCS_INV_REF   = 2'h3
    } ccs_inv_sel_type;

endpackage

// ### src/ccs_regs.sv
`timescale 1ns/100ps
// Notes on behaviour
// - ref select one picks internal reference
// - channel field picks pin B/C/D or reference
// - control bits three and two read zero
// - idle-stop halts all comparators in Idle
// - status 10..8 mirror event flags
// - status 2..0 mirror comparator outputs
module ccs_regs
    import ccs_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        nrst_in,
    input  wire logic [4:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic [2:0]  comp_out_in,
    input  wire logic        idle_mode_in,
    output logic [2:0]       noninv_ref_sel_out,
    output logic [5:0]       inv_sel_out,
    output logic [2:0]       comp_run_out,
    output logic             irq_out
);

    // Software-visible control fields per comparator
    logic [CCS_NUM-1:0] ref_source_select;
    logic [1:0]         inverting_channel_select [CCS_NUM];
    logic [CCS_NUM-1:0] comp_enable;
    logic [CCS_NUM-1:0] event_flag;
    logic               idle_stop_all;
    logic [CCS_NUM-1:0] irq_status;
    logic [CCS_NUM-1:0] irq_mask;
    logic [CCS_NUM-1:0] out_s1;
    logic [CCS_NUM-1:0] out_s2;
    logic [CCS_NUM-1:0] out_q;
    logic               idle_s1;
    logic               idle_s2;
    logic               busy;
    logic [CCS_NUM-1:0] run;
    logic [CCS_NUM-1:0] evt_set;

    // Address decode helpers
    function automatic logic is_reg(input logic [4:0] a, input logic [3:0] off, input logic bank);
        is_reg = (a[4] == bank) && (a[3:0] == off);
    endfunction

    function automatic logic [15:0] ctrl_word(input int i);
        ctrl_word = CCS_CTRL_RESET;
        ctrl_word[15]                   = comp_enable[i];
        ctrl_word[CCS_CTRL_EVT_BIT]     = event_flag[i];
        ctrl_word[CCS_CTRL_OUT_BIT]     = out_q[i];
        ctrl_word[CCS_CTRL_REF_SEL_BIT] = ref_source_select[i];
        ctrl_word[CCS_CTRL_CH_LSB +: 2] = inverting_channel_select[i];
    endfunction

    wire logic wr = avs_write_in && busy && avs_byteenable_in[0];
    wire logic wr_hi = avs_write_in && busy && avs_byteenable_in[1];

    // Pin-side inputs pass two flops before use
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            out_s1  <= 3'h0;
            out_s2  <= 3'h0;
            idle_s1 <= 1'b0;
            idle_s2 <= 1'b0;
        end else begin
            out_s1  <= comp_out_in;
            out_s2  <= out_s1;
            idle_s1 <= idle_mode_in;
            idle_s2 <= idle_s1;
        end
    end

    // Comparators run when enabled, unless idle-stop and Idle
    assign run = comp_enable & {CCS_NUM{!(idle_stop_all && idle_s2)}};

    // Output and event state per comparator
    generate
        for (genvar g = 0; g < CCS_NUM; g++) begin : g_cmp
            logic [3:0] off_c;
            assign off_c = 4'(g * 4);
            assign evt_set[g] = run[g] && (out_s2[g] != out_q[g]);
            always_ff @(posedge sys_clk_in) begin
                if (!nrst_in) begin
                    out_q[g] <= 1'b0;
                end else if (run[g]) begin
                    out_q[g] <= out_s2[g];
                end
            end
            // Event flag: hardware set wins over software clear
            always_ff @(posedge sys_clk_in) begin
                if (!nrst_in) begin
                    event_flag[g] <= 1'b0;
                end else if (evt_set[g]) begin
                    event_flag[g] <= 1'b1;
                end else if (wr_hi && is_reg(avs_address_in, off_c, 1'b0)) begin
                    event_flag[g] <= avs_writedata_in[CCS_CTRL_EVT_BIT];
                end
            end
            // Control fields
            always_ff @(posedge sys_clk_in) begin
                if (!nrst_in) begin
                    ref_source_select[g]        <= 1'b0;
                    inverting_channel_select[g] <= CCS_INV_PIN_B;
                    comp_enable[g]              <= 1'b0;
                end else begin
                    if (wr && is_reg(avs_address_in, off_c, 1'b0)) begin
                        ref_source_select[g] <= avs_writedata_in[CCS_CTRL_REF_SEL_BIT];
                        inverting_channel_select[g] <= avs_writedata_in[1:0];
                    end
                    if (wr_hi && is_reg(avs_address_in, off_c, 1'b0)) begin
                        comp_enable[g] <= avs_writedata_in[15];
                    end
                end
            end
            // Input routing to the analog front end
            always_ff @(posedge sys_clk_in) begin
                if (!nrst_in) begin
                    noninv_ref_sel_out[g]  <= 1'b0;
                    inv_sel_out[2*g +: 2]  <= CCS_INV_PIN_B;
                end else begin
                    noninv_ref_sel_out[g]  <= ref_source_select[g];
                    inv_sel_out[2*g +: 2]  <= inverting_channel_select[g];
                end
            end
        end
    endgenerate

    // Idle-stop bit: the only writable status bit
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            idle_stop_all <= 1'b0;
        end else if (wr_hi && is_reg(avs_address_in, CCS_OFF_STATUS, 1'b0)) begin
            idle_stop_all <= avs_writedata_in[CCS_STAT_IDLE_BIT];
        end
    end

    // Interrupt status: set by events, cleared by writing one
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            irq_status <= CCS_IRQ_RESET;
            irq_mask   <= CCS_IRQ_RESET;
        end else begin
            if (wr && is_reg(avs_address_in, CCS_OFF_IRQ_ST, 1'b1)) begin
                irq_status <= (irq_status & ~avs_writedata_in[2:0]) | evt_set;
            end else begin
                irq_status <= irq_status | evt_set;
            end
            if (wr && is_reg(avs_address_in, CCS_OFF_IRQ_MK, 1'b1)) begin
                irq_mask <= avs_writedata_in[2:0];
            end
        end
    end

    // Registered outputs
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            irq_out      <= 1'b0;
            comp_run_out <= 3'h0;
        end else begin
            irq_out      <= |(irq_status & irq_mask);
            comp_run_out <= run;
        end
    end

    // Bus: one wait cycle, answer on the second edge
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            busy                <= 1'b0;
            avs_waitrequest_out <= 1'b1;
        end else if (busy) begin
            busy                <= 1'b0;
            avs_waitrequest_out <= 1'b1;
        end else if (avs_read_in || avs_write_in) begin
            busy                <= 1'b1;
            avs_waitrequest_out <= 1'b0;
        end else begin
            avs_waitrequest_out <= 1'b1;
        end
    end

    // Read data mux; unmapped addresses read zero
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            avs_readdata_out <= 32'h0;
        end else if (avs_read_in && !busy) begin
            avs_readdata_out <= 32'h0;
            if (is_reg(avs_address_in, CCS_OFF_CTRL1, 1'b0)) begin
                avs_readdata_out[15:0] <= ctrl_word(0);
            end else if (is_reg(avs_address_in, CCS_OFF_CTRL2, 1'b0)) begin
                avs_readdata_out[15:0] <= ctrl_word(1);
            end else if (is_reg(avs_address_in, CCS_OFF_CTRL3, 1'b0)) begin
                avs_readdata_out[15:0] <= ctrl_word(2);
            end else if (is_reg(avs_address_in, CCS_OFF_STATUS, 1'b0)) begin
                avs_readdata_out[CCS_STAT_IDLE_BIT]        <= idle_stop_all;
                avs_readdata_out[CCS_STAT_EVT_LSB +: 3]   <= event_flag;
                avs_readdata_out[CCS_STAT_OUT_LSB +: 3]   <= out_q;
            end else if (is_reg(avs_address_in, CCS_OFF_IRQ_ST, 1'b1)) begin
                avs_readdata_out[2:0] <= irq_status;
            end else if (is_reg(avs_address_in, CCS_OFF_IRQ_MK, 1'b1)) begin
                avs_readdata_out[2:0] <= irq_mask;
            end
        end
    end

    // Routing outputs follow the control fields one cycle later
    AST_REF_ROUTE: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        noninv_ref_sel_out == $past(ref_source_select))
        else $error("reference routing mismatch");

    AST_REF_HOLD: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        !wr |=> $stable(ref_source_select))
        else $error("reference select changed without write");

    AST_INV_ROUTE: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        inv_sel_out[1:0] == $past(inverting_channel_select[0]))
        else $error("inverting routing mismatch");

    AST_INV_ROUTE_2: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        inv_sel_out[3:2] == $past(inverting_channel_select[1]))
        else $error("inverting routing mismatch on second comparator");

    AST_INV_ROUTE_3: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        inv_sel_out[5:4] == $past(inverting_channel_select[2]))
        else $error("inverting routing mismatch on third comparator");

    // Unimplemented control bits always read as zero
    AST_UNIMPL_ZERO: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        avs_read_in && !busy && avs_address_in == 5'h00 |=> avs_readdata_out[3:2] == 2'h0)
        else $error("unimplemented bits not zero");

    AST_UNIMPL_ZERO_2: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        avs_read_in && !busy && avs_address_in == 5'h04 |=> avs_readdata_out[3:2] == 2'h0)
        else $error("unimplemented bits not zero on second comparator");

    AST_UNIMPL_ZERO_3: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        avs_read_in && !busy && avs_address_in == 5'h08 |=> avs_readdata_out[3:2] == 2'h0)
        else $error("unimplemented bits not zero on third comparator");

    AST_CTRL_HIGH_ZERO: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        avs_read_in && !busy && !avs_address_in[4] |=> avs_readdata_out[31:16] == 16'h0)
        else $error("upper read half not zero");

    // Idle-stop halts every comparator, otherwise enable decides
    AST_IDLE_HALT: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        idle_stop_all && idle_s2 |=> comp_run_out == 3'h0)
        else $error("comparators run in idle");

    AST_IDLE_KEEP: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        !idle_stop_all |=> comp_run_out == $past(comp_enable))
        else $error("comparator halted without idle-stop");

    AST_AWAKE_KEEP: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        !idle_s2 |=> comp_run_out == $past(comp_enable))
        else $error("comparator halted outside idle");

    AST_RUN_OUT: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        comp_run_out == $past(run))
        else $error("run output mismatch");

    AST_OUT_FREEZE: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        run == 3'h0 |=> $stable(out_q))
        else $error("output moved while halted");

    // Status mirrors of event flags and outputs
    AST_EVT_MIRROR: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        avs_read_in && !busy && avs_address_in == 5'h0c |=> avs_readdata_out[10:8] == $past(event_flag))
        else $error("event mirror wrong");

    AST_OUT_MIRROR: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        avs_read_in && !busy && avs_address_in == 5'h0c |=> avs_readdata_out[2:0] == $past(out_q))
        else $error("output mirror wrong");

    AST_EVT_CTRL_MIRROR: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        avs_read_in && !busy && avs_address_in == 5'h00 |=>
        avs_readdata_out[9:8] == {$past(event_flag[0]), $past(out_q[0])})
        else $error("control word flags wrong");

    AST_OUT_FOLLOW: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        run[0] |=> out_q[0] == $past(out_s2[0]))
        else $error("output does not follow comparator");

    AST_EVT_SET_WINS: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        evt_set[0] |=> event_flag[0] && irq_status[0])
        else $error("event set lost");

    AST_EVT_SET_WINS_2: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        evt_set[1] |=> event_flag[1] && irq_status[1])
        else $error("event set lost on second comparator");

    AST_EVT_SET_WINS_3: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        evt_set[2] |=> event_flag[2] && irq_status[2])
        else $error("event set lost on third comparator");

    // Status writes reach only the idle-stop bit
    AST_STAT_WRITE: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        wr_hi && avs_address_in == 5'h0c |=> idle_stop_all == $past(avs_writedata_in[15]))
        else $error("idle-stop write lost");

    AST_IDLE_HOLD: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        !(wr_hi && avs_address_in == 5'h0c) |=> $stable(idle_stop_all))
        else $error("idle-stop changed without write");

    AST_STAT_RO_EVT: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        wr_hi && avs_address_in == 5'h0c && evt_set == 3'h0 |=> $stable(event_flag))
        else $error("status write changed event flags");

    AST_STAT_RO_OUT: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        wr && avs_address_in == 5'h0c && run == 3'h0 |=> $stable(out_q))
        else $error("status write changed outputs");

    AST_STAT_GAP_ZERO: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        avs_read_in && !busy && avs_address_in == 5'h0c |=>
        avs_readdata_out[14:11] == 4'h0 && avs_readdata_out[7:3] == 5'h0)
        else $error("unimplemented status bits not zero");

    // Bus handshake and interrupt bank
    AST_WAIT_ONE_LOW: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        !avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low for two cycles");

    AST_WAIT_ANSWER: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (avs_read_in || avs_write_in) && !busy |=> !avs_waitrequest_out)
        else $error("request not answered");

    AST_IRQ_LEVEL: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        irq_out == $past(|(irq_status & irq_mask)))
        else $error("interrupt level mismatch");

    AST_IRQ_CLR: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        wr && avs_address_in == 5'h10 && avs_writedata_in[0] && !evt_set[0] |=> !irq_status[0])
        else $error("interrupt status not cleared");

    AST_UNMAPPED_ZERO: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        avs_read_in && !busy && avs_address_in == 5'h18 |=> avs_readdata_out == 32'h0)
        else $error("unmapped read not zero");

    // Scenario covers
    COV_IDLE: cover property (@(posedge sys_clk_in) idle_stop_all && idle_s2 && |comp_enable);
    COV_EVT: cover property (@(posedge sys_clk_in) |evt_set);
    COV_IRQ: cover property (@(posedge sys_clk_in) irq_out);
    COV_STAT_READ: cover property (@(posedge sys_clk_in) avs_read_in && !busy && avs_address_in == 5'h0c);
    COV_IRQ_CLEAR: cover property (@(posedge sys_clk_in) wr && avs_address_in == 5'h10 && |irq_status);

endmodule
